// *** include/dprt_pkg.sv ***
// dprt_pkg: constants, command codes and helpers for the precharge/refresh block
// assumes: used by every design file of the block, compiled first
package dprt_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int CA_W      = 10;
  localparam int DQ_W      = 32;
  localparam int PREFETCH  = 4;
  localparam int GRP_W     = DQ_W * PREFETCH;
  localparam int BEAT_W    = 2;
  localparam int CNT_W     = 6;
  localparam int BL_W      = 5;
  localparam int LAT_W     = 4;
  localparam int RFC_W     = 8;
  localparam int CFG_W     = BL_W + 3 * LAT_W + RFC_W;

  // command/address bit positions
  localparam int CA_BIT0   = 0;
  localparam int CA_BIT1   = 1;
  localparam int CA_BIT2   = 2;
  localparam int CA_BIT3   = 3;
  localparam int CA_AB     = 4;
  localparam int CA_BA_LO  = 7;
  localparam int CA_AP_F   = 0;

  // reset values and counter constants
  localparam logic [BANK_W-1:0] REF_BANK_RST = 3'h0;
  localparam logic [CNT_W-1:0]  CNT_ZERO     = 6'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 6'h01;
  localparam logic [CNT_W-1:0]  RTP_FLOOR    = 6'h02;
  localparam logic [BEAT_W-1:0] BEAT_LAST    = 2'h3;

  typedef enum logic [2:0] {
    CMD_NOP   = 3'b000,
    CMD_ACT   = 3'b001,
    CMD_RD    = 3'b010,
    CMD_WR    = 3'b011,
    CMD_PRE   = 3'b100,
    CMD_BST   = 3'b101,
    CMD_REF   = 3'b110,
    CMD_OTHER = 3'b111
  } dprt_cmd_e;

  typedef struct packed {
    dprt_cmd_e         kind;
    logic [BANK_W-1:0] bank;
    logic              auto_close_flag;
    logic              all_banks_flag;
    logic              single_bank;
  } dprt_cmd_s;

  localparam dprt_cmd_s CMD_IDLE = '{kind: CMD_NOP, bank: 3'h0, auto_close_flag: 1'b0,
                                     all_banks_flag: 1'b0, single_bank: 1'b0};

  // bank select field of the rising half of the bus
  function automatic logic [BANK_W-1:0] dprt_ca_bank(input logic [CA_W-1:0] ca);
    dprt_ca_bank = ca[CA_BA_LO +: BANK_W];
  endfunction

  function automatic logic [NUM_BANKS-1:0] dprt_onehot(input logic [BANK_W-1:0] b);
    dprt_onehot = NUM_BANKS'(1) << b;
  endfunction
endpackage

// *** include/dprt_cmd_if.sv ***
// dprt_cmd_if: decoded command word passed from the decoder to the bank logic
// assumes: both ends run on the link clock
interface dprt_cmd_if;
  import dprt_pkg::*;
  dprt_cmd_s cmd;
  modport dec  (output cmd);
  modport core (input  cmd);
endinterface

// *** hdl/dprt_cmd_decode.sv ***
// dprt_cmd_decode: registers and decodes the command/address bus on each rising link clock edge with i_ce_lk high
// assumes: bus pins are launched by the controller on the link clock
module dprt_cmd_decode (
  // link clock and control
  input  wire logic                  i_ck,
  input  wire logic                  i_rst_lk,
  input  wire logic                  i_ce_lk,
  // command/address pins
  input  wire logic                  i_cs_n,
  input  wire logic [dprt_pkg::CA_W-1:0] i_ca_rise,
  input  wire logic [dprt_pkg::CA_W-1:0] i_ca_fall,
  // decoded command
  dprt_cmd_if.dec                    cmd_bus
);
  import dprt_pkg::*;

  dprt_cmd_s cmd;
  dprt_cmd_s next_cmd;

  always_comb begin
    next_cmd                 = CMD_IDLE;
    next_cmd.bank            = dprt_ca_bank(i_ca_rise);
    next_cmd.auto_close_flag = i_ca_fall[CA_AP_F];
    next_cmd.all_banks_flag  = i_ca_rise[CA_AB];
    next_cmd.single_bank     = !i_ca_rise[CA_BIT3];
    if (!i_cs_n) begin
      unique case ({i_ca_rise[CA_BIT0], i_ca_rise[CA_BIT1], i_ca_rise[CA_BIT2]})
        3'b010, 3'b011: next_cmd.kind = CMD_ACT;
        3'b100: next_cmd.kind = CMD_WR; // [R25]
        3'b101: next_cmd.kind = CMD_RD;
        3'b110: next_cmd.kind = i_ca_rise[CA_BIT3] ? CMD_PRE : CMD_BST; // [R23]
        3'b001: next_cmd.kind = CMD_REF; // [R16]
        default: next_cmd.kind = CMD_OTHER;
      endcase
    end
  end

  always_ff @(posedge i_ck) begin
    if (i_rst_lk) begin
      cmd <= CMD_IDLE;
    end else if (i_ce_lk) begin
      cmd <= next_cmd;
    end
  end

  assign cmd_bus.cmd = cmd;
endmodule

// *** hdl/dprt_wr_prefetch.sv ***
// dprt_wr_prefetch: gathers write beats into four-word groups for the array
// assumes: one beat per link cycle; a write command restarts the group
module dprt_wr_prefetch (
  // link clock and control
  input  wire logic                       i_ck,
  input  wire logic                       i_rst_lk,
  input  wire logic                       i_ce_lk,
  // write beats
  input  wire logic                       i_burst_start,
  input  wire logic [dprt_pkg::DQ_W-1:0]  i_wdata,
  input  wire logic                       i_wdata_valid,
  // array write
  output logic                            o_array_wr,
  output logic [dprt_pkg::GRP_W-1:0]      o_array_wdata
);
  import dprt_pkg::*;

  logic [BEAT_W-1:0]         beat;
  logic [BEAT_W-1:0]         next_beat;
  logic [GRP_W-DQ_W-1:0]     partial;
  logic [GRP_W-DQ_W-1:0]     next_partial;
  logic                      next_array_wr;
  logic [GRP_W-1:0]          next_array_wdata;

  always_comb begin
    next_beat        = i_burst_start ? '0 : beat;
    next_partial     = partial;
    next_array_wr    = 1'b0;
    next_array_wdata = o_array_wdata;
    if (i_wdata_valid) begin
      if (next_beat == BEAT_LAST) begin
        next_array_wr    = 1'b1; // [R5]
        next_array_wdata = {i_wdata, partial};
      end else begin
        next_partial = {i_wdata, partial[GRP_W-DQ_W-1:DQ_W]};
      end
      next_beat = next_beat + BEAT_W'(1);
    end
  end

  always_ff @(posedge i_ck) begin
    if (i_rst_lk) begin
      beat          <= '0;
      partial       <= '0;
      o_array_wr    <= 1'b0;
      o_array_wdata <= '0;
    end else if (i_ce_lk) begin
      beat          <= next_beat;
      partial       <= next_partial;
      o_array_wr    <= next_array_wr;
      o_array_wdata <= next_array_wdata;
    end
  end
endmodule

// *** hdl/dprt_top.sv ***
// dprt_top: bank closing, auto-close scheduling and refresh bank selection
// assumes: command pins and write beats arrive on i_ck; configuration and
// self-refresh exit come from logic on i_clk; configuration is quasi-static
//
// Contract
// [R1] precharge no sooner than half burst after read
// [R2] controller keeps minimum active and row precharge times
// [R3] read-to-precharge time starts half burst minus two after read
// [R4] write to precharge waits latency, half burst, one, recovery
// [R5] array writes only in full four-word groups
// [R6] auto-close flag high closes bank after burst
// [R7] read auto-close at half burst minus two plus max(2, rtp)
// [R8] write auto-close recovery cycles after burst ends
// [R9] activate after auto-close waits precharge and row cycle
// [R10] after read auto-close, same bank illegal; others spaced
// [R11] after write auto-close, same bank illegal; others spaced
// [R12] precharge one after read stop, longer after write stop
// [R13] precharges at least one clock apart
// [R14] precharge period counts from latest precharge to bank
// [R15] auto-close accesses never interrupted
// [R16] refresh decoded from select and lines zero to three
// [R17] single refresh steps round-robin over banks 0 to 7
// [R18] refresh counter clears on reset, self-refresh exit, all-bank refresh
// [R19] controller refreshes idle banks, waits refresh times
// [R20] only the single-refresh target is inaccessible
// [R21] controller waits single refresh time before follow-ons
// [R22] all-bank refresh only with all banks idle
// [R23] precharge decoded from select and lines zero to three
// [R24] all-banks flag selects all, else bits seven to nine
// [R25] write decoded from select and lines zero to two
// [R26] controller keeps per-bank countdowns in whole clocks
// [R27] controller keeps per-bank open state
module dprt_top (
  // system clock domain
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_ce,
  // configuration and self-refresh exit, system domain
  input  wire logic [dprt_pkg::BL_W-1:0]     i_burst_length,
  input  wire logic [dprt_pkg::LAT_W-1:0]    i_write_latency,
  input  wire logic [dprt_pkg::LAT_W-1:0]    i_rtp_clk,
  input  wire logic [dprt_pkg::LAT_W-1:0]    i_wr_clk,
  input  wire logic [dprt_pkg::RFC_W-1:0]    i_rfcpb_clk,
  input  wire logic                          i_sref_exit,
  // link pins
  input  wire logic                          i_ck,
  input  wire logic                          i_cs_n,
  input  wire logic [dprt_pkg::CA_W-1:0]     i_ca_rise,
  input  wire logic [dprt_pkg::CA_W-1:0]     i_ca_fall,
  input  wire logic [dprt_pkg::DQ_W-1:0]     i_wdata,
  input  wire logic                          i_wdata_valid,
  // array side, link domain
  output logic [dprt_pkg::NUM_BANKS-1:0]     o_array_pre,
  output logic                               o_array_wr,
  output logic [dprt_pkg::GRP_W-1:0]         o_array_wdata,
  output logic                               o_array_refresh,
  output logic [dprt_pkg::NUM_BANKS-1:0]     o_array_refresh_banks,
  // status, system domain
  output logic [dprt_pkg::NUM_BANKS-1:0]     o_bank_open,
  output logic [dprt_pkg::NUM_BANKS-1:0]     o_bank_refreshing,
  output logic [dprt_pkg::BANK_W-1:0]        o_refresh_bank,
  output logic                               o_illegal
);
  import dprt_pkg::*;

  // link-domain reset, enable and configuration
  logic             rst_meta;
  logic             rst_lk;
  logic             ce_meta;
  logic             ce_lk;
  logic [CFG_W-1:0] cfg_meta;
  logic [CFG_W-1:0] cfg_lk;

  always_ff @(posedge i_ck) begin
    rst_meta <= i_rst;
    rst_lk   <= rst_meta;
    ce_meta  <= i_ce;
    ce_lk    <= ce_meta;
    cfg_meta <= {i_burst_length, i_write_latency, i_rtp_clk, i_wr_clk, i_rfcpb_clk};
    cfg_lk   <= cfg_meta;
  end

  logic [BL_W-1:0]  cfg_bl;
  logic [LAT_W-1:0] cfg_wl;
  logic [LAT_W-1:0] cfg_rtp;
  logic [LAT_W-1:0] cfg_wr;
  logic [RFC_W-1:0] cfg_rfcpb;

  assign {cfg_bl, cfg_wl, cfg_rtp, cfg_wr, cfg_rfcpb} = cfg_lk;

  // self-refresh exit event, system toggle to link domain
  logic sref_tgl;
  logic next_sref_tgl;
  logic sref_meta;
  logic sref_s1;
  logic sref_s2;
  logic sref_evt;

  always_comb begin
    next_sref_tgl = sref_tgl ^ i_sref_exit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sref_tgl <= 1'b0;
    end else if (i_ce) begin
      sref_tgl <= next_sref_tgl;
    end
  end

  always_ff @(posedge i_ck) begin
    if (rst_lk) begin
      sref_meta <= 1'b0;
      sref_s1   <= 1'b0;
      sref_s2   <= 1'b0;
    end else if (ce_lk) begin
      sref_meta <= sref_tgl;
      sref_s1   <= sref_meta;
      sref_s2   <= sref_s1;
    end
  end

  assign sref_evt = sref_s1 ^ sref_s2;

  // command decode and write grouping
  dprt_cmd_if cmd_bus ();

  dprt_cmd_decode u_decode (
    .i_ck      (i_ck),
    .i_rst_lk  (rst_lk),
    .i_ce_lk   (ce_lk),
    .i_cs_n    (i_cs_n),
    .i_ca_rise (i_ca_rise),
    .i_ca_fall (i_ca_fall),
    .cmd_bus   (cmd_bus)
  );

  dprt_cmd_s cmd;
  assign cmd = cmd_bus.cmd;

  dprt_wr_prefetch u_prefetch (
    .i_ck          (i_ck),
    .i_rst_lk      (rst_lk),
    .i_ce_lk       (ce_lk),
    .i_burst_start (cmd.kind == CMD_WR),
    .i_wdata       (i_wdata),
    .i_wdata_valid (i_wdata_valid),
    .o_array_wr    (o_array_wr),
    .o_array_wdata (o_array_wdata)
  );

  // auto-close distances in link cycles
  logic [CNT_W-1:0] half_bl;
  logic [CNT_W-1:0] rtp_eff;
  logic [CNT_W-1:0] rd_close;
  logic [CNT_W-1:0] wr_close;

  always_comb begin
    half_bl  = CNT_W'(cfg_bl >> 1);
    rtp_eff  = (CNT_W'(cfg_rtp) > RTP_FLOOR) ? CNT_W'(cfg_rtp) : RTP_FLOOR;
    rd_close = half_bl + rtp_eff - RTP_FLOOR; // [R7]
    wr_close = CNT_W'(cfg_wl) + half_bl + CNT_ONE + CNT_W'(cfg_wr); // [R8]
  end

  // per-bank open state and auto-close countdown
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] next_open;
  logic [NUM_BANKS-1:0] pre_now;
  logic [NUM_BANKS-1:0] closing;
  logic [NUM_BANKS-1:0] cmd_sel;
  logic                 is_rw;

  assign cmd_sel = dprt_onehot(cmd.bank);
  assign is_rw   = (cmd.kind == CMD_RD) || (cmd.kind == CMD_WR);

  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
      logic [CNT_W-1:0] ac_cnt;
      logic [CNT_W-1:0] next_ac_cnt;
      logic             pre_hit;

      always_comb begin
        next_ac_cnt = (ac_cnt != CNT_ZERO) ? ac_cnt - CNT_ONE : ac_cnt;
        if (is_rw && cmd_sel[gb] && cmd.auto_close_flag) begin // [R6]
          next_ac_cnt = (cmd.kind == CMD_RD) ? rd_close : wr_close;
        end
      end

      always_ff @(posedge i_ck) begin
        if (rst_lk) begin
          ac_cnt <= CNT_ZERO;
        end else if (ce_lk) begin
          ac_cnt <= next_ac_cnt;
        end
      end

      assign pre_hit       = (cmd.kind == CMD_PRE) && (cmd.all_banks_flag || cmd_sel[gb]); // [R24]
      assign pre_now[gb]   = (ac_cnt == CNT_ONE) || pre_hit;
      assign closing[gb]   = ac_cnt != CNT_ZERO;
      assign next_open[gb] = !pre_now[gb] && (bank_open[gb] || (cmd.kind == CMD_ACT && cmd_sel[gb]));
    end
  endgenerate

  // refresh bank counter and single-bank refresh window
  logic [BANK_W-1:0]    ref_bank;
  logic [BANK_W-1:0]    next_ref_bank;
  logic [BANK_W-1:0]    rf_bank;
  logic [BANK_W-1:0]    next_rf_bank;
  logic [RFC_W-1:0]     rf_cnt;
  logic [RFC_W-1:0]     next_rf_cnt;
  logic [NUM_BANKS-1:0] refreshing;
  logic                 is_ref_all;
  logic                 is_ref_one;

  assign is_ref_all = (cmd.kind == CMD_REF) && !cmd.single_bank;
  assign is_ref_one = (cmd.kind == CMD_REF) && cmd.single_bank;

  always_comb begin
    next_ref_bank = ref_bank;
    next_rf_bank  = rf_bank;
    next_rf_cnt   = (rf_cnt != '0) ? rf_cnt - RFC_W'(1) : rf_cnt;
    if (sref_evt || is_ref_all) begin
      next_ref_bank = REF_BANK_RST; // [R18]
    end else if (is_ref_one) begin
      next_ref_bank = ref_bank + BANK_W'(1); // [R17]
      next_rf_bank  = ref_bank;
      next_rf_cnt   = cfg_rfcpb;
    end
  end

  // only the bank under single-bank refresh is marked busy
  assign refreshing = (rf_cnt != '0) ? dprt_onehot(rf_bank) : '0; // [R20]

  // access to a closing, refreshing or closed bank is flagged
  logic next_illegal_lk;

  always_comb begin
    next_illegal_lk = 1'b0;
    if (is_rw && |(cmd_sel & (closing | refreshing | ~bank_open))) begin
      next_illegal_lk = 1'b1;
    end
    if (cmd.kind == CMD_BST && |closing) begin
      next_illegal_lk = 1'b1;
    end
    if ((cmd.kind == CMD_ACT) && |(cmd_sel & refreshing)) begin
      next_illegal_lk = 1'b1;
    end
  end

  // link-domain registers
  logic illegal_tgl;
  logic next_illegal_tgl;

  assign next_illegal_tgl = illegal_tgl ^ next_illegal_lk;

  always_ff @(posedge i_ck) begin
    if (rst_lk) begin
      bank_open             <= '0;
      ref_bank              <= REF_BANK_RST;
      rf_bank               <= REF_BANK_RST;
      rf_cnt                <= '0;
      illegal_tgl           <= 1'b0;
      o_array_pre           <= '0;
      o_array_refresh       <= 1'b0;
      o_array_refresh_banks <= '0;
    end else if (ce_lk) begin
      bank_open             <= next_open;
      ref_bank              <= next_ref_bank;
      rf_bank               <= next_rf_bank;
      rf_cnt                <= next_rf_cnt;
      illegal_tgl           <= next_illegal_tgl;
      o_array_pre           <= pre_now;
      o_array_refresh       <= cmd.kind == CMD_REF;
      o_array_refresh_banks <= is_ref_one ? dprt_onehot(ref_bank) : (is_ref_all ? '1 : '0);
    end
  end

  // crossings into the system domain
  logic [BANK_W-1:0]    ref_gray;
  logic [BANK_W-1:0]    gray_meta;
  logic [BANK_W-1:0]    gray_sys;
  logic [NUM_BANKS-1:0] open_meta;
  logic [NUM_BANKS-1:0] busy_meta;
  logic                 ill_meta;
  logic                 ill_s1;
  logic                 ill_s2;
  logic [BANK_W-1:0]    next_refresh_bank;

  assign ref_gray = ref_bank ^ (ref_bank >> 1);

  always_comb begin
    next_refresh_bank = gray_sys;
    for (int i = BANK_W - 2; i >= 0; i--) begin
      next_refresh_bank[i] = next_refresh_bank[i + 1] ^ gray_sys[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gray_meta         <= '0;
      gray_sys          <= '0;
      open_meta         <= '0;
      busy_meta         <= '0;
      ill_meta          <= 1'b0;
      ill_s1            <= 1'b0;
      ill_s2            <= 1'b0;
      o_bank_open       <= '0;
      o_bank_refreshing <= '0;
      o_refresh_bank    <= REF_BANK_RST;
      o_illegal         <= 1'b0;
    end else if (i_ce) begin
      gray_meta         <= ref_gray;
      gray_sys          <= gray_meta;
      open_meta         <= bank_open;
      busy_meta         <= refreshing;
      ill_meta          <= illegal_tgl;
      ill_s1            <= ill_meta;
      ill_s2            <= ill_s1;
      o_bank_open       <= open_meta;
      o_bank_refreshing <= busy_meta;
      o_refresh_bank    <= next_refresh_bank;
      o_illegal         <= ill_s1 ^ ill_s2;
    end
  end
endmodule

// *** verification/dprt_top_checker.sv ***
// dprt_top_checker: timing checks on dprt_top ports
// assumes: burst 8, write latency 2, rtp 3, recovery 3
module dprt_top_checker (
  // clocks and reset
  input wire logic                           i_clk,
  input wire logic                           i_rst,
  input wire logic                           i_ck,
  // inputs watched
  input wire logic                           i_sref_exit,
  input wire logic                           i_cs_n,
  input wire logic [dprt_pkg::CA_W-1:0]      i_ca_rise,
  input wire logic [dprt_pkg::CA_W-1:0]      i_ca_fall,
  input wire logic                           i_wdata_valid,
  // outputs watched
  input wire logic [dprt_pkg::NUM_BANKS-1:0] o_array_pre,
  input wire logic                           o_array_wr,
  input wire logic                           o_array_refresh,
  input wire logic [dprt_pkg::NUM_BANKS-1:0] o_array_refresh_banks,
  input wire logic [dprt_pkg::BANK_W-1:0]    o_refresh_bank
);
  import dprt_pkg::*;
  logic [NUM_BANKS-1:0] hot, last_ref, next_last_ref;
  logic                 is_pre, is_ref, is_rd, is_wr;
  // last refreshed set; 8'h80 makes bank 0 the next single target
  always_comb begin
    hot = 8'h01 << i_ca_rise[9:7];
    is_pre = !i_cs_n && i_ca_rise[3:0] == 4'hB;
    is_ref = !i_cs_n && i_ca_rise[2:0] == 3'h4;
    is_rd = !i_cs_n && i_ca_rise[2:0] == 3'h5;
    is_wr = !i_cs_n && i_ca_rise[2:0] == 3'h1;
    next_last_ref = last_ref;
    if (o_array_refresh) begin
      next_last_ref = (o_array_refresh_banks == 8'hFF) ? 8'h80 : o_array_refresh_banks;
    end
  end
  always_ff @(posedge i_ck) begin
    if (i_rst) begin
      last_ref <= 8'h80;
    end else begin
      last_ref <= next_last_ref;
    end
  end
  property p_pre_one;
    @(posedge i_ck) disable iff (i_rst) is_pre && !i_ca_rise[4] |-> ##2 o_array_pre == $past(hot, 2);
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("pre bank");
  property p_pre_all;
    @(posedge i_ck) disable iff (i_rst) is_pre && i_ca_rise[4] |-> ##2 o_array_pre == 8'hFF;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("pre all");
  property p_ref_all;
    @(posedge i_ck) disable iff (i_rst)
      is_ref && i_ca_rise[3] |-> ##2 o_array_refresh && o_array_refresh_banks == 8'hFF;
  endproperty
  a_ref_all: assert property (p_ref_all) else $error("ref all");
  property p_ref_one;
    @(posedge i_ck) disable iff (i_rst)
      is_ref && !i_ca_rise[3] |-> ##2 o_array_refresh && $onehot(o_array_refresh_banks);
  endproperty
  a_ref_one: assert property (p_ref_one) else $error("ref one");
  property p_ref_rr;
    @(posedge i_ck) disable iff (i_rst) o_array_refresh && o_array_refresh_banks != 8'hFF
      |-> o_array_refresh_banks == {last_ref[6:0], last_ref[7]};
  endproperty
  a_ref_rr: assert property (p_ref_rr) else $error("ref order");
  property p_rd_ac;
    @(posedge i_ck) disable iff (i_rst) is_rd && i_ca_fall[0]
      |-> ##6 (o_array_pre & $past(hot, 6)) == 8'h00 ##1 (o_array_pre & $past(hot, 7)) != 8'h00;
  endproperty
  a_rd_ac: assert property (p_rd_ac) else $error("rd close");
  property p_wr_ac;
    @(posedge i_ck) disable iff (i_rst) is_wr && i_ca_fall[0]
      |-> ##11 (o_array_pre & $past(hot, 11)) == 8'h00 ##1 (o_array_pre & $past(hot, 12)) != 8'h00;
  endproperty
  a_wr_ac: assert property (p_wr_ac) else $error("wr close");
  property p_rd_keep;
    @(posedge i_ck) disable iff (i_rst) is_rd && !i_ca_fall[0] |-> ##7 (o_array_pre & $past(hot, 7)) == 8'h00;
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("rd keep");
  property p_wr_grp;
    @(posedge i_ck) disable iff (i_rst) o_array_wr |-> $past(i_wdata_valid, 2);
  endproperty
  a_wr_grp: assert property (p_wr_grp) else $error("wr group");
  property p_sref;
    @(posedge i_clk) disable iff (i_rst) i_sref_exit |-> ##[1:16] o_refresh_bank == 3'h0;
  endproperty
  a_sref: assert property (p_sref) else $error("sref clear");
endmodule

bind dprt_top dprt_top_checker u_chk (.*);

// *** verification/dprt_ctrl_model.sv ***
// dprt_ctrl_model: controller side driving command pins and write beats
// assumes: tasks called by the bench; drives 1 ns after each link rising edge
module dprt_ctrl_model (
  // link clock
  input  wire logic                   i_ck,
  // command pins and write beats
  output logic                        o_cs_n,
  output logic [dprt_pkg::CA_W-1:0]   o_ca_rise,
  output logic [dprt_pkg::CA_W-1:0]   o_ca_fall,
  output logic [dprt_pkg::DQ_W-1:0]   o_wdata,
  output logic                        o_wdata_valid,
  // mirror of the next single refresh bank
  output logic [dprt_pkg::BANK_W-1:0] o_ref_ptr
);
  import dprt_pkg::*;
  initial begin
    o_cs_n = 1'b1;
    o_ca_rise = 10'h155;
    o_ca_fall = 10'h2AA;
    o_wdata = 32'h5A5A5A5A;
    o_wdata_valid = 1'b0;
    o_ref_ptr = 3'h0;
  end
  // code holds lines three to zero of the rising half
  task automatic cmd(input logic [3:0] code, input logic [2:0] bank, input logic ab, input logic ap);
    @(posedge i_ck);
    #1;
    o_cs_n = 1'b0;
    o_ca_rise = {bank, 2'b00, ab, code};
    o_ca_fall = {9'h000, ap};
    o_wdata = ~o_wdata;
    o_wdata_valid = 1'b0;
    if (code[2:0] == 3'h4) o_ref_ptr = code[3] ? 3'h0 : o_ref_ptr + 3'h1;
  endtask
  task automatic beat(input logic [DQ_W-1:0] d);
    @(posedge i_ck);
    #1;
    o_cs_n = 1'b1;
    o_ca_rise = ~o_ca_rise;
    o_wdata = d;
    o_wdata_valid = 1'b1;
  endtask
  // deselected lines toggle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_ck);
      #1;
      o_cs_n = 1'b1;
      o_ca_rise = ~o_ca_rise;
      o_ca_fall = ~o_ca_fall;
      o_wdata = ~o_wdata;
      o_wdata_valid = 1'b0;
    end
  endtask
endmodule

// *** verification/dprt_top_tb.sv ***
// dprt_top_tb: self-checking bench for dprt_top with a controller model
// assumes: fixed burst 8, latency 2, rtp 3, recovery 3; refresh time random
module dprt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dprt_pkg::*;
  logic                 i_clk, i_rst, i_ce, i_sref_exit, i_ck, i_cs_n, i_wdata_valid;
  logic [BL_W-1:0]      i_burst_length;
  logic [LAT_W-1:0]     i_write_latency, i_rtp_clk, i_wr_clk;
  logic [RFC_W-1:0]     i_rfcpb_clk;
  logic [CA_W-1:0]      i_ca_rise, i_ca_fall;
  logic [DQ_W-1:0]      i_wdata;
  logic [NUM_BANKS-1:0] o_array_pre, o_array_refresh_banks, o_bank_open, o_bank_refreshing, pre_acc, ref_acc;
  logic                 o_array_wr, o_array_refresh, o_illegal;
  logic [GRP_W-1:0]     o_array_wdata, wr_dat;
  logic [BANK_W-1:0]    o_refresh_bank, ref_ptr, bk, bn;
  logic [31:0]          rnd;
  logic [DQ_W-1:0]      d [4];
  int                   miscompares, samples_checked, ill_n, wr_n, il0, w0, b, k;
  dprt_ctrl_model ctl (.i_ck(i_ck), .o_cs_n(i_cs_n), .o_ca_rise(i_ca_rise), .o_ca_fall(i_ca_fall),
    .o_wdata(i_wdata), .o_wdata_valid(i_wdata_valid), .o_ref_ptr(ref_ptr));
  dprt_top DUT (.*);
  always #5 i_clk = ~i_clk;
  always #16 i_ck = ~i_ck;
  always @(posedge i_ck) begin
    pre_acc = pre_acc | o_array_pre;
    if (o_array_refresh === 1'b1) ref_acc = ref_acc | o_array_refresh_banks;
    if (o_array_wr === 1'b1) wr_n++;
    if (o_array_wr === 1'b1) wr_dat = o_array_wdata;
  end
  always @(posedge i_clk) if (o_illegal === 1'b1) ill_n++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [GRP_W-1:0] exp, input logic [GRP_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_open(input logic [2:0] bank, input logic v);
    int n;
    for (n = 0; n < 40 && o_bank_open[bank] !== v; n++) @(posedge i_clk);
    if (n == 40) begin
      miscompares++;
      print_verdict();
    end
    chk("bank_open", v, o_bank_open[bank]);
  endtask
  initial begin
    {i_clk, i_ck, i_rst, i_ce, i_sref_exit} = 5'b00110;
    {i_burst_length, i_write_latency, i_rtp_clk, i_wr_clk} = {5'h08, 4'h2, 4'h3, 4'h3};
    {miscompares, samples_checked, ill_n, wr_n} = '0;
    rnd = 32'hD64642FE;
    i_rfcpb_clk = 8'h10 + {4'h0, rnd[3:0]};
    {pre_acc, ref_acc, wr_dat} = '0;
    repeat (13) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    ctl.idle(6);
    for (b = 0; b < 8; b++) begin
      bk = b[2:0];
      bn = bk + 3'h1;
      ctl.cmd(4'h2, bk, 1'b0, 1'b0);
      ctl.cmd(4'h2, bn, 1'b0, 1'b0);
      ctl.idle(3);
      pre_acc = '0;
      ctl.cmd(4'hB, bk, 1'b0, 1'b0);
      ctl.cmd(4'hB, bn, 1'b0, 1'b0);
      ctl.idle(3);
      chk("array_pre", (8'h01 << bk) | (8'h01 << bn), pre_acc);
    end
    pre_acc = '0;
    rnd = lfsr(rnd);
    ctl.cmd(4'hB, rnd[2:0], 1'b1, 1'b0);
    ctl.idle(3);
    chk("array_pre", 8'hFF, pre_acc);
    $display("test precharge done");
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      bk = rnd[2:0];
      ctl.cmd(4'h2, bk, 1'b0, 1'b0);
      ctl.idle(4);
      wait_open(bk, 1'b1);
      ctl.cmd(k ? 4'h1 : 4'h5, bk, 1'b0, 1'b0);
      ctl.idle(14);
      chk("bank_open", 1'b1, o_bank_open[bk]);
      ctl.cmd(k ? 4'h1 : 4'h5, bk, 1'b0, 1'b1);
      ctl.idle(14);
      wait_open(bk, 1'b0);
      il0 = ill_n;
      ctl.cmd(4'h5, bk, 1'b0, 1'b0);
      ctl.idle(4);
      repeat (8) @(posedge i_clk);
      chk("illegal", 1, ill_n - il0);
    end
    $display("test auto_close done");
    rnd = lfsr(rnd);
    bk = rnd[2:0];
    ctl.cmd(4'h2, bk, 1'b0, 1'b0);
    ctl.idle(3);
    w0 = wr_n;
    ctl.cmd(4'h1, bk, 1'b0, 1'b0);
    for (k = 0; k < 3; k++) ctl.beat(rnd ^ k);
    ctl.cmd(4'h1, bk, 1'b0, 1'b0);
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      d[k] = rnd;
      ctl.beat(rnd);
    end
    ctl.idle(10);
    chk("wr_count", 1, wr_n - w0);
    chk("wr_data", {d[3], d[2], d[1], d[0]}, wr_dat);
    ctl.cmd(4'hB, bk, 1'b1, 1'b0);
    ctl.idle(4);
    ref_acc = '0;
    ctl.cmd(4'hC, 3'h0, 1'b0, 1'b0);
    ctl.idle(40);
    chk("ref_banks", 8'hFF, ref_acc);
    chk("ref_bank", 3'h0, o_refresh_bank);
    $display("test write_group done");
    for (k = 0; k < 9; k++) begin
      bk = k[2:0];
      bn = bk + 3'h1;
      ref_acc = '0;
      il0 = ill_n;
      ctl.cmd(4'h4, 3'h0, 1'b0, 1'b0);
      ctl.idle(2);
      repeat (4) @(posedge i_clk);
      chk("ref_banks", 8'h01 << bk, ref_acc);
      chk("refreshing", 1'b1, o_bank_refreshing[bk]);
      if (k == 3) ctl.cmd(4'h2, bk, 1'b0, 1'b0);
      ctl.cmd(4'h2, bn, 1'b0, 1'b0);
      ctl.idle(2);
      ctl.cmd(4'h5, bn, 1'b0, 1'b0);
      ctl.idle(8);
      ctl.cmd(4'hB, bn, 1'b0, 1'b0);
      ctl.idle(int'(i_rfcpb_clk));
      chk("illegal", k == 3, ill_n - il0);
      chk("ref_bank", ref_ptr, o_refresh_bank);
    end
    $display("test refresh done");
    i_ce = 1'b0;
    ctl.idle(3);
    ctl.cmd(4'h2, 3'h0, 1'b0, 1'b0);
    ctl.idle(3);
    i_ce = 1'b1;
    ctl.idle(4);
    wait_open(3'h0, 1'b0);
    $display("test clock_enable done");
    @(posedge i_clk);
    #1;
    i_sref_exit = 1'b1;
    ctl.o_ref_ptr = 3'h0;
    @(posedge i_clk);
    #1;
    i_sref_exit = 1'b0;
    repeat (16) @(posedge i_clk);
    chk("ref_bank", ref_ptr, o_refresh_bank);
    $display("test sref_exit done");
    print_verdict();
  end
endmodule
